/* pso_core.sv */
// execute-stage product scaling and sticky overflow flag, avalon slave
//
// Operation
// - overflow of a result sets the sticky flag, bit 6; else unchanged.
// - flag stays set until reset, a status write, a flag-testing conditional or a saturate with wrap count zero.
// - a branch testing the flag clears it, true or false outcome.
// - 32-bit accumulator add/sub overflows outside 80000000..7fffffff.
// - 16-bit add/sub overflows outside 8000..7fff.
// - compare instructions never touch the overflow flag.
// - abs and negate of 80000000 accumulator set the flag.
// - negating a half holding 8000 sets the flag.
// - negating the 64-bit pair at its minimum sets the flag.
// - saturate clears flag if wrap count zero, else sets it.
// - product store writes low or high half of scaled product.
// - product compare forms acc minus scaled product, stores nothing.
// - integer multiply loads scaled multiplicand times operand.
// - mixed multiply: multiplicand signed, operand unsigned, then scaled.
// - dual multiply adds scaled high product to acc, low to product.
// - multiply-subtract takes old product from acc before new load.
// - scale field three bits: left one, none, right one to six.
// - right scaling sign-extends and drops low bits.
// - wrap count is six-bit signed, wrapping in range.
//
// Chosen here: the Avalon-MM interface to the registers and the register offsets.
`timescale 1ns/1ns
`default_nettype none
module pso_core
    import pso_pkg::*;
(
    // clock and reset
    input  wire logic              REF_CLK,
    input  wire logic              SRST,
    // avalon-mm slave
    input  wire logic [ADDR_W-1:0] AVS_ADDRESS,
    input  wire logic              AVS_READ,
    input  wire logic              AVS_WRITE,
    input  wire logic [DATA_W-1:0] AVS_WRITEDATA,
    output logic      [DATA_W-1:0] AVS_READDATA,
    output logic                   AVS_WAITREQUEST,
    // status
    output logic                   OV_FLAG,
    output logic      [5:0]        WRAP_COUNT
);
    logic [31:0] main_sum_reg_q, main_sum_reg_d;
    logic [31:0] prod_q,         prod_d;
    logic [31:0] multiplicand_reg_q;
    logic [31:0] opnd_q;
    logic [31:0] store_q,        store_d;
    logic [31:0] rdata_q,        rdata_d;
    logic        wait_q;
    pso_status_t st_q,           st_d;

    // one wait cycle per access keeps read data registered
    logic        req, wr_go, cmd_go;
    logic [31:0] st_word;
    pso_op_t     op;
    assign req    = AVS_READ | AVS_WRITE;
    assign wr_go  = AVS_WRITE & ~wait_q;
    assign cmd_go = wr_go & (AVS_ADDRESS == OFS_CMD);
    assign op     = pso_op_t'(AVS_WRITEDATA[4:0]);
    assign st_word = {16'h0000, st_q.wrap, st_q.scale, st_q.ov,
                      4'h0, st_q.tcond, 1'b0};

    assign rdata_d =
        (AVS_ADDRESS == OFS_STATUS) ? st_word :
        (AVS_ADDRESS == OFS_ACC)    ? main_sum_reg_q :
        (AVS_ADDRESS == OFS_PROD)   ? prod_q :
        (AVS_ADDRESS == OFS_MCAND)  ? multiplicand_reg_q :
        (AVS_ADDRESS == OFS_OPND)   ? opnd_q :
        (AVS_ADDRESS == OFS_STORE)  ? store_q : WORD_RST;

    // scaled product, multiplier paths
    logic [31:0] sh_p, sh_hi, sh_lo;
    logic [63:0] mul_raw, sh_mul;
    logic [31:0] hi_raw, lo_raw;
    logic        mixed;
    logic [64:0] mixed_raw;
    assign mixed     = (op == OP_IMPYXU);
    // operand zero-extended so it reads as unsigned
    assign mixed_raw = 65'($signed(multiplicand_reg_q)
                           * $signed({1'b0, opnd_q}));
    assign mul_raw   = mixed ? mixed_raw[63:0] :
                       64'($signed(multiplicand_reg_q) * $signed(opnd_q));
    assign hi_raw    = 32'($signed(multiplicand_reg_q[31:16])
                           * $signed(opnd_q[31:16]));
    assign lo_raw    = 32'($signed(multiplicand_reg_q[15:0])
                           * $signed(opnd_q[15:0]));

    pso_scale #(.W(32)) u_sc_p (
        .din  (prod_q),
        .sel  (st_q.scale),
        .dout (sh_p)
    );
    // full 64-bit product is scaled so right shifts pull in high bits
    pso_scale #(.W(64)) u_sc_mul (
        .din  (mul_raw),
        .sel  (st_q.scale),
        .dout (sh_mul)
    );
    pso_scale #(.W(32)) u_sc_hi (
        .din  (hi_raw),
        .sel  (st_q.scale),
        .dout (sh_hi)
    );
    pso_scale #(.W(32)) u_sc_lo (
        .din  (lo_raw),
        .sel  (st_q.scale),
        .dout (sh_lo)
    );

    function automatic logic ovf32(input logic [31:0] a, input logic [31:0] b,
                                   input logic [31:0] r, input logic sub);
        logic bs;
        bs = sub ? ~b[31] : b[31];
        ovf32 = (a[31] == bs) && (r[31] != a[31]);
    endfunction : ovf32

    function automatic logic ovf16(input logic [15:0] a, input logic [15:0] b,
                                   input logic [15:0] r, input logic sub);
        logic bs;
        bs = sub ? ~b[15] : b[15];
        ovf16 = (a[15] == bs) && (r[15] != a[15]);
    endfunction : ovf16

    // sums shared by the op decode
    logic [31:0] a, add_op, sub_op, add_p, sub_p, add_hi, add_lo, neg_a;
    logic [15:0] add16, sub16, neg16;
    logic [63:0] pair, neg_pair;
    logic        wrap_zero, wrap_neg;
    assign a       = main_sum_reg_q;
    assign add_op  = a + opnd_q;
    assign sub_op  = a - opnd_q;
    assign add_p   = a + sh_p;
    assign sub_p   = a - sh_p;
    assign add_hi  = a + sh_hi;
    assign add_lo  = prod_q + sh_lo;
    assign neg_a   = 32'h0 - a;
    assign add16   = a[15:0] + opnd_q[15:0];
    assign sub16   = a[15:0] - opnd_q[15:0];
    assign neg16   = 16'h0 - a[15:0];
    assign pair    = {a, prod_q};
    assign neg_pair = 64'h0 - pair;
    assign wrap_zero = (st_q.wrap == WRAP_RST);
    assign wrap_neg  = st_q.wrap[WRAP_W-1];

    logic v_set, v_clr, acc_ovf, acc_up;
    always_comb begin
        main_sum_reg_d = main_sum_reg_q;
        prod_d         = prod_q;
        store_d        = store_q;
        st_d           = st_q;
        v_set          = 1'b0;
        v_clr          = 1'b0;
        acc_ovf        = 1'b0;
        acc_up         = 1'b0;
        if (wr_go && AVS_ADDRESS == OFS_STATUS) begin
            st_d.tcond = AVS_WRITEDATA[TCOND_BIT];
            st_d.ov    = AVS_WRITEDATA[OV_BIT];
            st_d.scale = AVS_WRITEDATA[SCALE_LSB +: SCALE_W];
            st_d.wrap  = AVS_WRITEDATA[WRAP_LSB +: WRAP_W];
        end
        if (wr_go && AVS_ADDRESS == OFS_ACC) begin
            main_sum_reg_d = AVS_WRITEDATA;
        end
        if (wr_go && AVS_ADDRESS == OFS_PROD) begin
            prod_d = AVS_WRITEDATA;
        end
        if (cmd_go) begin
            unique case (op)
                OP_ADD32: begin
                    main_sum_reg_d = add_op;
                    acc_ovf = ovf32(a, opnd_q, add_op, 1'b0);
                end
                OP_SUB32: begin
                    main_sum_reg_d = sub_op;
                    acc_ovf = ovf32(a, opnd_q, sub_op, 1'b1);
                end
                OP_ADD16: begin
                    main_sum_reg_d = {a[31:16], add16};
                    v_set = ovf16(a[15:0], opnd_q[15:0], add16, 1'b0);
                end
                OP_SUB16: begin
                    main_sum_reg_d = {a[31:16], sub16};
                    v_set = ovf16(a[15:0], opnd_q[15:0], sub16, 1'b1);
                end
                // compares leave every register and the flag alone
                OP_CMP32, OP_CMP16: begin
                end
                OP_MAC: begin
                    main_sum_reg_d = add_p;
                    acc_ovf = ovf32(a, sh_p, add_p, 1'b0);
                end
                OP_LOADP: begin
                    main_sum_reg_d = sh_p;
                end
                OP_MSUB: begin
                    main_sum_reg_d = sub_p;
                    acc_ovf = ovf32(a, sh_p, sub_p, 1'b1);
                end
                OP_STLO: store_d = {16'h0000, sh_p[15:0]};
                OP_STHI: store_d = {16'h0000, sh_p[31:16]};
                // difference is not used here; store and the flag keep their values
                OP_CMPP: store_d = store_q;
                OP_IMPY, OP_IMPYXU: prod_d = sh_mul[31:0];
                OP_DUAL: begin
                    main_sum_reg_d = add_hi;
                    prod_d = add_lo;
                    acc_ovf = ovf32(a, sh_hi, add_hi, 1'b0);
                    v_set = ovf32(prod_q, sh_lo, add_lo, 1'b0);
                end
                OP_IMPYS: begin
                    main_sum_reg_d = sub_op - prod_q + opnd_q;
                    acc_ovf = ovf32(a, prod_q, a - prod_q, 1'b1);
                    prod_d = sh_mul[31:0];
                end
                OP_ABS: begin
                    main_sum_reg_d = a[31] ? neg_a : a;
                    v_set = (a == MIN32);
                end
                OP_NEG: begin
                    main_sum_reg_d = neg_a;
                    v_set = (a == MIN32);
                end
                OP_CNEG: begin
                    main_sum_reg_d = st_q.tcond ? neg_a : a;
                    v_set = st_q.tcond && (a == MIN32);
                end
                OP_NEGHALF: begin
                    main_sum_reg_d = {a[31:16], neg16};
                    v_set = (a[15:0] == MIN16);
                end
                OP_NEG64: begin
                    {main_sum_reg_d, prod_d} = neg_pair;
                    v_set = (pair == MIN64);
                end
                OP_SAT32: begin
                    if (!wrap_zero) begin
                        main_sum_reg_d = wrap_neg ? MIN32 : MAX32;
                    end
                    st_d.wrap = WRAP_RST;
                    v_set = !wrap_zero;
                    v_clr = wrap_zero;
                end
                OP_SATW: begin
                    if (!wrap_zero) begin
                        {main_sum_reg_d, prod_d} = wrap_neg ? MIN64 : MAX64;
                    end
                    st_d.wrap = WRAP_RST;
                    v_set = !wrap_zero;
                    v_clr = wrap_zero;
                end
                // branch, move and call share one condition test
                OP_COND: v_clr = opnd_q[COND_OV_BIT];
                default: begin
                end
            endcase
            // accumulator overflow also steps the signed wrap count
            if (acc_ovf) begin
                acc_up = ~main_sum_reg_d[31];
                st_d.wrap = acc_up ? st_q.wrap - 6'h01 : st_q.wrap + 6'h01;
            end
            // overflow sets, tests and saturate clear
            if (v_set || acc_ovf) begin
                st_d.ov = 1'b1;
            end else if (v_clr) begin
                st_d.ov = 1'b0;
            end
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (SRST) begin
            main_sum_reg_q <= WORD_RST;
            prod_q         <= WORD_RST;
            store_q        <= WORD_RST;
            st_q           <= '{wrap: WRAP_RST, scale: SCALE_RST,
                                ov: OV_RST, tcond: TCOND_RST};
        end else begin
            main_sum_reg_q <= main_sum_reg_d;
            prod_q         <= prod_d;
            store_q        <= store_d;
            st_q           <= st_d;
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (SRST) begin
            multiplicand_reg_q <= WORD_RST;
            opnd_q             <= WORD_RST;
            rdata_q            <= WORD_RST;
            wait_q             <= 1'b1;
        end else begin
            if (wr_go && AVS_ADDRESS == OFS_MCAND) begin
                multiplicand_reg_q <= AVS_WRITEDATA;
            end
            if (wr_go && AVS_ADDRESS == OFS_OPND) begin
                opnd_q <= AVS_WRITEDATA;
            end
            if (AVS_READ && wait_q) begin
                rdata_q <= rdata_d;
            end
            wait_q <= ~(req & wait_q);
        end
    end

    assign AVS_READDATA    = rdata_q;
    assign AVS_WAITREQUEST = wait_q;
    assign OV_FLAG         = st_q.ov;
    assign WRAP_COUNT      = st_q.wrap;

    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (SRST);

    logic is_op;
    logic st_wr;
    assign is_op = cmd_go;
    assign st_wr = wr_go && AVS_ADDRESS == OFS_STATUS;

    chk_ov_sticky: assert property (
        st_q.ov && !st_wr && !(is_op && (op == OP_SAT32 || op == OP_SATW
            || (op == OP_COND && opnd_q[COND_OV_BIT]))) |=> st_q.ov)
        else $error("overflow flag dropped without a clearing event");
    chk_cond_clear: assert property (
        is_op && op == OP_COND && opnd_q[COND_OV_BIT] |=> !st_q.ov)
        else $error("flag test did not clear overflow");
    chk_add32_ovf: assert property (
        is_op && op == OP_ADD32 && opnd_q[31] == a[31]
            && add_op[31] != a[31] |=> st_q.ov)
        else $error("32-bit add overflow not flagged");
    chk_sub16_ovf: assert property (
        is_op && op == OP_SUB16 && opnd_q[15] != a[15]
            && sub16[15] != a[15] |=> st_q.ov)
        else $error("16-bit subtract overflow not flagged");
    chk_cmp_keep: assert property (
        is_op && (op == OP_CMP32 || op == OP_CMP16 || op == OP_CMPP)
            |=> $stable(st_q.ov))
        else $error("compare changed the overflow flag");
    chk_neg_min: assert property (
        is_op && op == OP_NEG && a == MIN32
            |=> st_q.ov && main_sum_reg_q == MIN32)
        else $error("negate of minimum not flagged");
    chk_neg64_min: assert property (
        is_op && op == OP_NEG64 && pair == MIN64 |=> st_q.ov)
        else $error("64-bit negate of minimum not flagged");
    chk_sat_flag: assert property (
        is_op && (op == OP_SAT32 || op == OP_SATW)
            |=> st_q.ov == ($past(st_q.wrap) != WRAP_RST)
                && st_q.wrap == WRAP_RST)
        else $error("saturate flag or wrap count wrong");
    chk_mac_sum: assert property (
        is_op && op == OP_MAC
            |=> main_sum_reg_q == $past(main_sum_reg_q) + $past(sh_p))
        else $error("accumulate did not add scaled product");
    chk_store_hi: assert property (
        is_op && op == OP_STHI |=> store_q[15:0] == $past(sh_p[31:16]))
        else $error("high store not from scaled product");
    chk_bus_wait: assert property (
        req && wait_q |=> !wait_q ##1 wait_q)
        else $error("waitrequest did not pulse low once");

    cov_sat_set: cover property (is_op && op == OP_SAT32 && !wrap_zero);
    cov_cond_clr: cover property (st_q.ov ##1 is_op && op == OP_COND);
    cov_dual: cover property (is_op && op == OP_DUAL);
endmodule : pso_core
`default_nettype wire

/* pso_pkg.sv */
// package: offsets, field layout, reset values and command codes
package pso_pkg;
    localparam int          DATA_W      = 32;
    localparam int          ADDR_W      = 5;
    // byte offsets of the register window
    localparam logic [4:0]  OFS_STATUS  = 5'h00;
    localparam logic [4:0]  OFS_ACC     = 5'h04;
    localparam logic [4:0]  OFS_PROD    = 5'h08;
    localparam logic [4:0]  OFS_MCAND   = 5'h0c;
    localparam logic [4:0]  OFS_OPND    = 5'h10;
    localparam logic [4:0]  OFS_CMD     = 5'h14;
    localparam logic [4:0]  OFS_STORE   = 5'h18;
    // status word field positions
    localparam int          TCOND_BIT   = 1;
    localparam int          OV_BIT      = 6;
    localparam int          SCALE_LSB   = 7;
    localparam int          WRAP_LSB    = 10;
    localparam int          SCALE_W     = 3;
    localparam int          WRAP_W      = 6;
    localparam int          COND_OV_BIT = 0;
    // reset values
    localparam logic [2:0]  SCALE_RST   = 3'h0;
    localparam logic [5:0]  WRAP_RST    = 6'h00;
    localparam logic        OV_RST      = 1'b0;
    localparam logic        TCOND_RST   = 1'b0;
    localparam logic [31:0] WORD_RST    = 32'h0000_0000;
    // scale codes
    localparam logic [2:0]  SCALE_LEFT1 = 3'h0;
    localparam logic [2:0]  SCALE_NONE  = 3'h1;
    // extreme signed values
    localparam logic [31:0] MIN32       = 32'h8000_0000;
    localparam logic [31:0] MAX32       = 32'h7fff_ffff;
    localparam logic [15:0] MIN16       = 16'h8000;
    localparam logic [63:0] MIN64       = 64'h8000_0000_0000_0000;
    localparam logic [63:0] MAX64       = 64'h7fff_ffff_ffff_ffff;

    typedef enum logic [4:0] {
        OP_ADD32   = 5'h00, OP_SUB32   = 5'h01, OP_ADD16  = 5'h02,
        OP_SUB16   = 5'h03, OP_CMP32   = 5'h04, OP_CMP16  = 5'h05,
        OP_MAC     = 5'h06, OP_MSUB    = 5'h07, OP_STLO   = 5'h08,
        OP_STHI    = 5'h09, OP_CMPP    = 5'h0a, OP_IMPY   = 5'h0b,
        OP_IMPYXU  = 5'h0c, OP_DUAL    = 5'h0d, OP_IMPYS  = 5'h0e,
        OP_ABS     = 5'h0f, OP_NEG     = 5'h10, OP_CNEG   = 5'h11,
        OP_NEGHALF = 5'h12, OP_NEG64   = 5'h13, OP_SAT32  = 5'h14,
        OP_SATW    = 5'h15, OP_COND    = 5'h16, OP_LOADP  = 5'h17
    } pso_op_t;

    typedef struct packed {
        logic [5:0] wrap;
        logic [2:0] scale;
        logic       ov;
        logic       tcond;
    } pso_status_t;
endpackage : pso_pkg

/* pso_scale.sv */
// product scaler: left by one, pass, or arithmetic right by one to six
`timescale 1ns/1ns
`default_nettype none
module pso_scale
    import pso_pkg::*;
#(
    parameter int W = 32
) (
    // value and mode
    input  wire logic [W-1:0] din,
    input  wire logic [2:0]   sel,
    // scaled value
    output logic [W-1:0]      dout
);
    logic [2:0] rsh;
    assign rsh  = sel - 3'h1;
    // right shifts keep the sign, low bits fall away
    assign dout = (sel == SCALE_LEFT1) ? {din[W-2:0], 1'b0} :
                  (sel == SCALE_NONE)  ? din :
                  W'($signed(din) >>> rsh);
endmodule : pso_scale
`default_nettype wire

/* tb_product_shift_overflow_flag.sv */
// self-checking bench for the product scaling and overflow flag block
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin \
    n_tests++; \
    if ((g) !== (e)) begin \
        err_count++; \
        $display("[ERR] %s exp %h got %h", nm, e, g); \
    end \
end
module tb_product_shift_overflow_flag
    import pso_pkg::*;
;
    logic        ref_clk = 1'b0;
    logic        srst    = 1'b1;
    logic [4:0]  addr    = 5'h00;
    logic        rd_en   = 1'b0;
    logic        wr_en   = 1'b0;
    logic [31:0] wdata   = 32'h0;
    logic [31:0] rdata;
    logic        waitreq;
    logic        ov;
    logic [5:0]  wrap;
    logic [31:0] q;
    int          err_count = 0;
    int          n_tests   = 0;

    always #20 ref_clk = ~ref_clk;

    pso_core pso_core_i (
        .REF_CLK         (ref_clk),
        .SRST            (srst),
        .AVS_ADDRESS     (addr),
        .AVS_READ        (rd_en),
        .AVS_WRITE       (wr_en),
        .AVS_WRITEDATA   (wdata),
        .AVS_READDATA    (rdata),
        .AVS_WAITREQUEST (waitreq),
        .OV_FLAG         (ov),
        .WRAP_COUNT      (wrap)
    );

    task automatic stop_test;
        $display("checks %0d errors %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : stop_test

    // request held until waitrequest is sampled low; bounded wait
    task automatic xfer(input logic w, input logic [4:0] a,
                        input logic [31:0] d);
        int k;
        @(posedge ref_clk);
        addr  <= a;
        wdata <= d;
        wr_en <= w;
        rd_en <= ~w;
        k = 0;
        do begin
            @(posedge ref_clk);
            k++;
        end while (waitreq !== 1'b0 && k < 20);
        q = rdata;
        wr_en <= 1'b0;
        rd_en <= 1'b0;
        if (waitreq !== 1'b0) begin
            err_count++;
            $display("[ERR] bus wait exp 0 got %b", waitreq);
            stop_test();
        end
    endtask : xfer

    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask : wr

    task automatic rd(input logic [4:0] a);
        xfer(1'b0, a, 32'h0);
    endtask : rd

    // two edges so the command result has surely landed
    task automatic cmd(input pso_op_t op);
        xfer(1'b1, OFS_CMD, {27'h0, op});
        repeat (2) @(posedge ref_clk);
    endtask : cmd

    function automatic logic [31:0] st(input logic [5:0] w,
        input logic [2:0] s, input logic v, input logic t);
        return {16'h0, w, s, v, 4'h0, t, 1'b0};
    endfunction : st

    // bench's own model of the scaler, kept apart from the design
    function automatic logic [31:0] scl(input logic [31:0] p,
                                        input logic [2:0] c);
        if (c == 3'h0)
            return p << 1;
        return $signed(p) >>> (c - 3'h1);
    endfunction : scl

    task automatic t_regs;
        rd(OFS_STATUS);
        `CHK("status rst", 32'h0, q)
        `CHK("ov rst", 1'b0, ov)
        wr(OFS_STATUS, 32'hffff_ffff);
        rd(OFS_STATUS);
        `CHK("status bits", 32'h0000_ffc2, q)
        `CHK("wrap pin", 6'h3f, wrap)
        rd(5'h1c);
        `CHK("unmapped", 32'h0, q)
    endtask : t_regs

    task automatic t_add;
        wr(OFS_STATUS, st(6'h00, SCALE_NONE, 1'b0, 1'b0));
        wr(OFS_ACC, 32'h7fff_fffe);
        wr(OFS_OPND, 32'h0000_0001);
        cmd(OP_ADD32);
        `CHK("no ovf", 1'b0, ov)
        cmd(OP_ADD32);
        `CHK("add32 ovf", 1'b1, ov)
        `CHK("wrap up", 6'h01, wrap)
        cmd(OP_ADD32);
        `CHK("sticky", 1'b1, ov)
        wr(OFS_OPND, 32'h0000_0000);
        cmd(OP_COND);
        `CHK("untested keep", 1'b1, ov)
        wr(OFS_OPND, 32'h0000_0001);
        cmd(OP_COND);
        `CHK("cond clr", 1'b0, ov)
        wr(OFS_ACC, MIN32);
        cmd(OP_SUB32);
        `CHK("sub32 ovf", 1'b1, ov)
        `CHK("wrap down", 6'h00, wrap)
        wr(OFS_STATUS, st(6'h1f, SCALE_NONE, 1'b0, 1'b0));
        wr(OFS_ACC, MAX32);
        cmd(OP_ADD32);
        `CHK("wrap edge", 6'h20, wrap)
        wr(OFS_STATUS, st(6'h00, SCALE_NONE, 1'b0, 1'b0));
        wr(OFS_ACC, 32'h0000_7fff);
        cmd(OP_ADD16);
        `CHK("add16 ovf", 1'b1, ov)
        wr(OFS_STATUS, st(6'h00, SCALE_NONE, 1'b0, 1'b0));
        wr(OFS_ACC, 32'h0000_8000);
        cmd(OP_SUB16);
        `CHK("sub16 ovf", 1'b1, ov)
    endtask : t_add

    // every compare here would overflow if it were a subtraction
    task automatic t_cmp;
        wr(OFS_STATUS, st(6'h00, SCALE_NONE, 1'b0, 1'b0));
        wr(OFS_ACC, 32'h8000_8000);
        wr(OFS_OPND, 32'h0001_0001);
        wr(OFS_PROD, MAX32);
        cmd(OP_CMP32);
        cmd(OP_CMP16);
        cmd(OP_CMPP);
        `CHK("cmp ov", 1'b0, ov)
        rd(OFS_ACC);
        `CHK("cmp acc", 32'h8000_8000, q)
    endtask : t_cmp

    task automatic t_scale;
        logic [31:0] s;
        for (int c = 0; c < 8; c++) begin
            s = scl(32'h8000_0f00, 3'(c));
            wr(OFS_STATUS, st(6'h00, 3'(c), 1'b0, 1'b0));
            wr(OFS_PROD, 32'h8000_0f00);
            wr(OFS_ACC, 32'h0);
            cmd(OP_MAC);
            rd(OFS_ACC);
            `CHK("mac", s, q)
            cmd(OP_MSUB);
            rd(OFS_ACC);
            `CHK("msub", 32'h0, q)
            cmd(OP_STLO);
            rd(OFS_STORE);
            `CHK("store lo", {16'h0, s[15:0]}, q)
            cmd(OP_STHI);
            rd(OFS_STORE);
            `CHK("store hi", {16'h0, s[31:16]}, q)
            cmd(OP_LOADP);
            rd(OFS_ACC);
            `CHK("load", s, q)
        end
    endtask : t_scale

    task automatic t_neg;
        pso_op_t     ops[5] = '{OP_ABS, OP_NEG, OP_CNEG, OP_NEGHALF,
                                OP_NEG64};
        logic [31:0] av[5]  = '{MIN32, MIN32, MIN32, 32'h0000_8000, MIN32};
        wr(OFS_PROD, 32'h0);
        for (int i = 0; i < 5; i++) begin
            wr(OFS_STATUS, st(6'h00, SCALE_NONE, 1'b0, 1'b1));
            wr(OFS_ACC, av[i]);
            cmd(ops[i]);
            `CHK("neg ovf", 1'b1, ov)
        end
        wr(OFS_STATUS, st(6'h00, SCALE_NONE, 1'b0, 1'b0));
        wr(OFS_ACC, 32'h8000_0001);
        cmd(OP_NEG);
        `CHK("neg ok", 1'b0, ov)
        wr(OFS_ACC, MIN32);
        cmd(OP_CNEG);
        `CHK("cneg off", 1'b0, ov)
    endtask : t_neg

    task automatic t_sat;
        pso_op_t so[2] = '{OP_SAT32, OP_SATW};
        for (int i = 0; i < 2; i++) begin
            wr(OFS_STATUS, st(6'h00, SCALE_NONE, 1'b1, 1'b0));
            cmd(so[i]);
            `CHK("sat clr", 1'b0, ov)
            wr(OFS_STATUS, st(6'h3e, SCALE_NONE, 1'b0, 1'b0));
            cmd(so[i]);
            `CHK("sat set", 1'b1, ov)
        end
        // mid-run reset must drop the flag left set above
        srst <= 1'b1;
        repeat (2) @(posedge ref_clk);
        srst <= 1'b0;
        @(posedge ref_clk);
        `CHK("ov after rst", 1'b0, ov)
    endtask : t_sat

    task automatic t_mul;
        wr(OFS_STATUS, st(6'h00, SCALE_LEFT1, 1'b0, 1'b0));
        wr(OFS_MCAND, 32'h0000_0003);
        wr(OFS_OPND, 32'h0000_0005);
        cmd(OP_IMPY);
        rd(OFS_PROD);
        `CHK("impy", 32'h0000_001e, q)
        // low word alike for either sign; right scaling exposes the top
        wr(OFS_STATUS, st(6'h00, 3'h2, 1'b0, 1'b0));
        wr(OFS_MCAND, 32'hffff_ffff);
        wr(OFS_OPND, MIN32);
        cmd(OP_IMPYXU);
        rd(OFS_PROD);
        `CHK("mixed", 32'hc000_0000, q)
        wr(OFS_STATUS, st(6'h00, SCALE_NONE, 1'b0, 1'b0));
        wr(OFS_ACC, 32'h0000_000a);
        wr(OFS_PROD, 32'h0000_0003);
        wr(OFS_MCAND, 32'h0000_0002);
        wr(OFS_OPND, 32'h0000_0004);
        cmd(OP_IMPYS);
        rd(OFS_ACC);
        `CHK("imsub acc", 32'h0000_0007, q)
        rd(OFS_PROD);
        `CHK("imsub prod", 32'h0000_0008, q)
        wr(OFS_STATUS, st(6'h00, 3'h2, 1'b0, 1'b0));
        wr(OFS_ACC, 32'h0000_0064);
        wr(OFS_PROD, 32'h0000_0032);
        wr(OFS_MCAND, 32'h0002_0003);
        wr(OFS_OPND, 32'h0004_0005);
        cmd(OP_DUAL);
        rd(OFS_ACC);
        `CHK("dual acc", 32'h0000_0068, q)
        rd(OFS_PROD);
        `CHK("dual prod", 32'h0000_0039, q)
    endtask : t_mul

    initial begin
        repeat (16) @(posedge ref_clk);
        srst <= 1'b0;
        t_regs();
        t_add();
        t_cmp();
        t_scale();
        t_neg();
        t_sat();
        t_mul();
        stop_test();
    end
endmodule : tb_product_shift_overflow_flag
`default_nettype wire
